/* File: rtl/fsd_pkg.sv */
// package: constants, types and code tables of the fault and status display manager
package fsd_pkg;

    // clock and timing
    localparam int CLK_HZ = 40_000_000;
    localparam int SAT_TIME_MS = 1000;
    localparam int SAT_CYCLES = SAT_TIME_MS * (CLK_HZ / 1000);
    localparam int BLINK_HALF_MS = 500;
    localparam int BLINK_CYCLES = BLINK_HALF_MS * (CLK_HZ / 1000);
    localparam int TMR_W = 26;

    // heat sink trip point, degrees C
    localparam logic [7:0] TEMP_LIMIT_C = 8'h5a;

    // fault and sequencer flag vector sizes
    localparam int N_FATAL = 10;
    localparam int N_NONFATAL = 10;
    localparam int N_SEQ_FLAGS = 6;

    // fatal bit positions: F00..F07 at 0..7
    localparam int FAT_CUR_REG = 4;
    localparam int FAT_OVERTEMP = 5;
    localparam int FAT_LADDER = 8;
    localparam int FAT_SEQPRG = 9;
    // non-fatal bit positions: F51..F58 at 0..7
    localparam int NF_FOLLOW = 4;
    localparam int NF_POS_EOT = 8;
    localparam int NF_NEG_EOT = 9;

    // display characters
    typedef logic [3:0] fsd_char_t;
    localparam fsd_char_t CH_F = 4'ha;
    localparam fsd_char_t CH_L = 4'hb;
    localparam fsd_char_t CH_D = 4'hc;
    localparam fsd_char_t CH_E = 4'hd;
    localparam fsd_char_t CH_P = 4'he;
    localparam fsd_char_t CH_BLANK = 4'hf;
    localparam fsd_char_t CH_0 = 4'h0;
    localparam fsd_char_t CH_1 = 4'h1;
    localparam fsd_char_t CH_2 = 4'h2;
    localparam fsd_char_t CH_9 = 4'h9;

    // second and third characters of each fault, index 0 is the highest priority
    localparam logic [N_FATAL-1:0][7:0] FATAL_DIGITS = {
        8'h97, 8'h98, 8'h07, 8'h06, 8'h05, 8'h04, 8'h03, 8'h02, 8'h01, 8'h00};
    localparam logic [N_NONFATAL-1:0][7:0] NF_DIGITS = {
        8'hb2, 8'hb1, 8'h58, 8'h57, 8'h56, 8'h55, 8'h54, 8'h53, 8'h52, 8'h51};

    typedef struct packed {
        logic flash;
        logic lit;
        fsd_char_t c0;
        fsd_char_t c1;
        fsd_char_t c2;
    } fsd_disp_s;

    // avalon-mm request bundle
    typedef struct packed {
        logic read;
        logic write;
        logic [4:0] address;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } fsd_avs_req_s;

    // register map (byte addresses)
    localparam logic [4:0] REG_CTRL = 5'h00;
    localparam logic [4:0] REG_FE_LIMIT = 5'h04;
    localparam logic [4:0] REG_STATUS = 5'h08;
    localparam logic [4:0] REG_FAULTS = 5'h0c;
    localparam logic [4:0] REG_SEQ = 5'h10;

    // control fields and reset values
    localparam int CTRL_RUN = 0;
    localparam int CTRL_CONFIGURED = 1;
    localparam int CTRL_POS_MODE = 2;
    localparam logic [2:0] CTRL_RST = 3'h0;
    localparam logic [15:0] FE_LIMIT_RST = 16'hffff;
    localparam int FAULTS_NF_LSB = 16;

    typedef enum logic [1:0] {SQ_TOP, SQ_TEST, SQ_CALL} fsd_seq_e;

endpackage : fsd_pkg

/* File: rtl/fsd_fault_status_mgr.sv */
// fault and status manager: fault latching, priority display, amplifier gating, index dispatcher
// Operation
// - no fault or status: show d while disabled, E while enabled.
// - abnormal non-fault condition shows a flashing three-character status code.
// - any fault switches off the amplifier stage and shows its code.
// - fault shown as flashing F plus two digits.
// - fatal fault clears only by power cycle then fresh enable.
// - non-fatal fault clears on enable re-assert after removal, cause gone.
// - display highest priority: fatal, non-fatal, limit faults, then status.
// - fatal hardware codes F00 through F07.
// - ladder scan error gives F98, program execution error gives F97.
// - F04 on regulation out of tolerance or saturation held one second.
// - F05 when heat sink exceeds 90 C.
// - non-fatal codes F51 through F58.
// - F55 only in position modes, at configured maximum following error.
// - unconfigured drive shows F99 and refuses enable.
// - positive end-of-travel gives FL1, negative gives FL2.
// - L01 when clockwise limit made, enabled, no fault.
// - L02 when counter-clockwise limit made, enabled, no fault.
// - d means enable input or host command holds drive off, no fault.
// - show P while motor phasing runs.
// - active faults also readable by the host.
// - scan six flags in order, call matching index routine, branch to top.
//
// Chosen here: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module fsd_fault_status_mgr
    import fsd_pkg::*;
#(
    parameter int SAT_CNT = SAT_CYCLES,
    parameter int BLINK_CNT = BLINK_CYCLES
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // register bus
    input wire fsd_avs_req_s avs_req_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // pins
    input wire logic enable_pin_i,
    input wire logic pos_eot_pin_i,
    input wire logic neg_eot_pin_i,
    input wire logic cw_limit_pin_i,
    input wire logic ccw_limit_pin_i,
    // internal condition detectors
    input wire logic [7:0] fatal_cond_i,
    input wire logic cur_reg_oot_i,
    input wire logic cur_fb_sat_i,
    input wire logic [7:0] heatsink_temp_i,
    input wire logic ladder_err_i,
    input wire logic seq_prog_err_i,
    input wire logic [7:0] nonfatal_cond_i,
    input wire logic [15:0] follow_err_i,
    input wire logic phasing_i,
    // dispatcher
    input wire logic [N_SEQ_FLAGS-1:0] ladder_to_sequencer_flag_i,
    input wire logic sub_done_i,
    output logic sub_call_o,
    output logic [2:0] sub_index_o,
    // drive outputs
    output logic amp_enable_o,
    output logic host_fault_o,
    output fsd_disp_s disp_o
);

    // pin synchronisers
    logic [4:0] pin_meta_ff;
    logic [4:0] pin_sync_ff;
    logic en_prev_ff;
    logic armed_ff;

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_meta_ff <= 5'h00;
            pin_sync_ff <= 5'h00;
        end else begin
            pin_meta_ff <= {ccw_limit_pin_i, cw_limit_pin_i, neg_eot_pin_i, pos_eot_pin_i, enable_pin_i};
            pin_sync_ff <= pin_meta_ff;
        end
    end

    wire en_s = pin_sync_ff[0];
    wire pos_eot_s = pin_sync_ff[1];
    wire neg_eot_s = pin_sync_ff[2];
    wire cw_lim_s = pin_sync_ff[3];
    wire ccw_lim_s = pin_sync_ff[4];
    wire en_rise = en_s & ~en_prev_ff;

    // registers
    logic [2:0] ctrl_ff;
    logic [15:0] fe_limit_ff;
    logic wait_ff;
    logic [31:0] rdata_ff;
    wire bus_req = avs_req_i.read | avs_req_i.write;
    wire bus_take = bus_req & ~wait_ff;
    wire wr_ctrl = bus_take & avs_req_i.write & (avs_req_i.address == REG_CTRL);
    wire wr_fel = bus_take & avs_req_i.write & (avs_req_i.address == REG_FE_LIMIT);
    wire configured = ctrl_ff[CTRL_CONFIGURED];

    // fault detectors
    logic [TMR_W-1:0] sat_cnt_ff;
    wire sat_trip = cur_fb_sat_i & (sat_cnt_ff == TMR_W'(SAT_CNT - 1));
    wire fe_trip = ctrl_ff[CTRL_POS_MODE] & (follow_err_i >= fe_limit_ff);
    logic [N_FATAL-1:0] fatal_ff;
    logic [N_NONFATAL-1:0] nonfatal_ff;
    logic [N_FATAL-1:0] fatal_cond;
    logic [N_NONFATAL-1:0] nf_cond;

    always_comb begin
        fatal_cond = {seq_prog_err_i, ladder_err_i, fatal_cond_i};
        fatal_cond[FAT_CUR_REG] = fatal_cond_i[FAT_CUR_REG] | cur_reg_oot_i | sat_trip;
        fatal_cond[FAT_OVERTEMP] = fatal_cond_i[FAT_OVERTEMP] | (heatsink_temp_i > TEMP_LIMIT_C);
        nf_cond = {neg_eot_s, pos_eot_s, nonfatal_cond_i};
        nf_cond[NF_FOLLOW] = fe_trip;
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sat_cnt_ff <= '0;
        end else if (!cur_fb_sat_i || sat_trip) begin
            sat_cnt_ff <= '0;
        end else begin
            sat_cnt_ff <= sat_cnt_ff + TMR_W'(1);
        end
    end

    // sticky fault bits; a present cause always wins over the clear
    logic [N_FATAL-1:0] nxt_fatal;
    logic [N_NONFATAL-1:0] nxt_nonfatal;
    genvar gi;
    generate
        for (gi = 0; gi < N_FATAL; gi++) begin : g_fatal
            assign nxt_fatal[gi] = fatal_ff[gi] | fatal_cond[gi];
        end
        for (gi = 0; gi < N_NONFATAL; gi++) begin : g_nonfatal
            assign nxt_nonfatal[gi] = nf_cond[gi] | (nonfatal_ff[gi] & ~en_rise);
        end
    endgenerate

    wire nxt_any_fault = (|nxt_fatal) | (|nxt_nonfatal);
    wire nxt_amp = en_s & armed_ff & ctrl_ff[CTRL_RUN] & configured & ~nxt_any_fault;

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fatal_ff <= '0;
            nonfatal_ff <= '0;
            en_prev_ff <= 1'b1;
            armed_ff <= 1'b0;
            amp_enable_o <= 1'b0;
            host_fault_o <= 1'b0;
        end else begin
            fatal_ff <= nxt_fatal;
            nonfatal_ff <= nxt_nonfatal;
            en_prev_ff <= en_s;
            armed_ff <= armed_ff | en_rise;
            amp_enable_o <= nxt_amp;
            host_fault_o <= nxt_any_fault;
        end
    end

    // priority display selection, lowest priority first so later wins
    fsd_disp_s nxt_disp;
    logic blink_ph_ff;
    logic [TMR_W-1:0] blink_cnt_ff;

    always_comb begin
        nxt_disp = '{flash: 1'b0, lit: 1'b1, c0: amp_enable_o ? CH_E : CH_D, c1: CH_BLANK, c2: CH_BLANK};
        if (amp_enable_o && ccw_lim_s) begin
            nxt_disp = '{flash: 1'b1, lit: 1'b1, c0: CH_L, c1: CH_0, c2: CH_2};
        end
        if (amp_enable_o && cw_lim_s) begin
            nxt_disp = '{flash: 1'b1, lit: 1'b1, c0: CH_L, c1: CH_0, c2: CH_1};
        end
        if (phasing_i) begin
            nxt_disp = '{flash: 1'b0, lit: 1'b1, c0: CH_P, c1: CH_BLANK, c2: CH_BLANK};
        end
        for (int i = N_NONFATAL - 1; i >= NF_POS_EOT; i--) begin
            if (nonfatal_ff[i]) begin
                nxt_disp = '{flash: 1'b1, lit: 1'b1, c0: CH_F, c1: NF_DIGITS[i][7:4], c2: NF_DIGITS[i][3:0]};
            end
        end
        if (!configured) begin
            nxt_disp = '{flash: 1'b1, lit: 1'b1, c0: CH_F, c1: CH_9, c2: CH_9};
        end
        for (int i = NF_POS_EOT - 1; i >= 0; i--) begin
            if (nonfatal_ff[i]) begin
                nxt_disp = '{flash: 1'b1, lit: 1'b1, c0: CH_F, c1: NF_DIGITS[i][7:4], c2: NF_DIGITS[i][3:0]};
            end
        end
        for (int i = N_FATAL - 1; i >= 0; i--) begin
            if (fatal_ff[i]) begin
                nxt_disp = '{flash: 1'b1, lit: 1'b1, c0: CH_F, c1: FATAL_DIGITS[i][7:4], c2: FATAL_DIGITS[i][3:0]};
            end
        end
        nxt_disp.lit = ~(nxt_disp.flash & blink_ph_ff);
    end

    wire blink_wrap = (blink_cnt_ff == TMR_W'(BLINK_CNT - 1));

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            blink_cnt_ff <= '0;
            blink_ph_ff <= 1'b0;
            disp_o <= '{flash: 1'b0, lit: 1'b1, c0: CH_D, c1: CH_BLANK, c2: CH_BLANK};
        end else begin
            blink_cnt_ff <= blink_wrap ? '0 : blink_cnt_ff + TMR_W'(1);
            blink_ph_ff <= blink_ph_ff ^ blink_wrap;
            disp_o <= nxt_disp;
        end
    end

    // index dispatcher
    fsd_seq_e seq_st_ff;
    logic [2:0] seq_idx_ff;
    wire seq_last = (seq_idx_ff == 3'(N_SEQ_FLAGS - 1));
    wire seq_flag = ladder_to_sequencer_flag_i[seq_idx_ff];

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            seq_st_ff <= SQ_TOP;
            seq_idx_ff <= 3'h0;
            sub_call_o <= 1'b0;
            sub_index_o <= 3'h0;
        end else begin
            unique case (seq_st_ff)
                SQ_TOP: begin
                    seq_idx_ff <= 3'h0;
                    seq_st_ff <= SQ_TEST;
                end
                SQ_TEST: begin
                    if (seq_flag) begin
                        seq_st_ff <= SQ_CALL;
                        sub_call_o <= 1'b1;
                        sub_index_o <= seq_idx_ff + 3'h1;
                    end else if (seq_last) begin
                        seq_st_ff <= SQ_TOP;
                    end else begin
                        seq_idx_ff <= seq_idx_ff + 3'h1;
                    end
                end
                SQ_CALL: begin
                    if (sub_done_i) begin
                        sub_call_o <= 1'b0;
                        seq_st_ff <= seq_last ? SQ_TOP : SQ_TEST;
                        seq_idx_ff <= seq_last ? 3'h0 : seq_idx_ff + 3'h1;
                    end
                end
            endcase
        end
    end

    // avalon slave: waitrequest drops one cycle after a request, transfer completes at that edge
    logic [31:0] nxt_rdata;
    always_comb begin
        nxt_rdata = 32'h0000_0000;
        unique case (avs_req_i.address)
            REG_CTRL: nxt_rdata = {29'h0, ctrl_ff};
            REG_FE_LIMIT: nxt_rdata = {16'h0000, fe_limit_ff};
            REG_STATUS: nxt_rdata = {12'h000, disp_o.c0, disp_o.c1, disp_o.c2, 4'h0,
                                     sub_call_o, |fatal_ff, host_fault_o, amp_enable_o};
            REG_FAULTS: nxt_rdata = {6'h00, nonfatal_ff, 6'h00, fatal_ff};
            REG_SEQ: nxt_rdata = {18'h0, ladder_to_sequencer_flag_i, 5'h00, sub_index_o};
            default: nxt_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wait_ff <= 1'b1;
            rdata_ff <= 32'h0000_0000;
            ctrl_ff <= CTRL_RST;
            fe_limit_ff <= FE_LIMIT_RST;
        end else begin
            wait_ff <= ~(bus_req & wait_ff);
            if (bus_req && wait_ff) begin
                rdata_ff <= avs_req_i.read ? nxt_rdata : 32'h0000_0000;
            end
            if (wr_ctrl && avs_req_i.byteenable[0]) begin
                ctrl_ff <= avs_req_i.writedata[2:0];
            end
            if (wr_fel && avs_req_i.byteenable[0]) begin
                fe_limit_ff[7:0] <= avs_req_i.writedata[7:0];
            end
            if (wr_fel && avs_req_i.byteenable[1]) begin
                fe_limit_ff[15:8] <= avs_req_i.writedata[15:8];
            end
        end
    end

    assign avs_readdata_o = rdata_ff;
    assign avs_waitrequest_o = wait_ff;

    // checks
    sequence s_call_start;
        seq_st_ff == SQ_TEST && seq_flag;
    endsequence
    sequence s_call_open;
        sub_call_o && sub_index_o == $past(seq_idx_ff) + 3'h1;
    endsequence

    AST_FAULT_AMP_OFF: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        ((|fatal_ff) || (|nonfatal_ff)) |-> !amp_enable_o)
        else $error("amplifier on while a fault is latched");
    AST_FATAL_STICKY: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        ##1 ((fatal_ff & $past(fatal_ff)) == $past(fatal_ff)))
        else $error("fatal fault bit cleared without reset");
    AST_NF_CLEAR: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (($past(nonfatal_ff) & ~nonfatal_ff) != '0) |-> $past(en_rise))
        else $error("non-fatal fault cleared without enable rising");
    AST_UNCONF_OFF: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        !configured |=> !amp_enable_o)
        else $error("drive enabled while unconfigured");
    AST_TEMP_TRIP: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (heatsink_temp_i > TEMP_LIMIT_C) |=> fatal_ff[FAT_OVERTEMP] ##1 disp_o.c0 == CH_F)
        else $error("over-temperature not latched and shown");
    AST_FATAL_SHOWN: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        fatal_ff[0] |=> disp_o.c0 == CH_F && disp_o.c1 == CH_0 && disp_o.c2 == CH_0 && disp_o.flash)
        else $error("highest fatal fault not displayed");
    AST_IDLE_LETTER: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (fatal_ff == '0 && nonfatal_ff == '0 && configured && !phasing_i && !cw_lim_s && !ccw_lim_s)
        |=> disp_o.c0 == (($past(amp_enable_o)) ? CH_E : CH_D) && !disp_o.flash)
        else $error("normal letter wrong");
    AST_FE_POS_ONLY: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        $rose(nonfatal_ff[NF_FOLLOW]) |-> $past(ctrl_ff[CTRL_POS_MODE]))
        else $error("following error raised outside position mode");
    AST_SEQ_CALL: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        s_call_start |=> s_call_open)
        else $error("set flag did not call its index routine");
    AST_BUS_ANSWER: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
        (bus_req && wait_ff) |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
        else $error("bus answer not one cycle late");

endmodule : fsd_fault_status_mgr

/* File: dv/fsd_far_side.sv */
// far-side model: external controller sequence select and routine completion
`timescale 1ns/1ps
module fsd_far_side
    import fsd_pkg::*;
(
    // bench commands
    input wire logic ref_clk_i,
    input wire logic [2:0] seq_sel_i,
    input wire logic [N_SEQ_FLAGS-1:0] extra_i,
    input wire logic [3:0] done_lat_i,
    // block side
    input wire logic sub_call_i,
    output logic [N_SEQ_FLAGS-1:0] flag_o,
    output logic sub_done_o
);
    logic [3:0] wait_ff = 4'h0;
    logic done_ff = 1'b0;
    logic [N_SEQ_FLAGS-1:0] dec;
    // select codes 1..6 raise one flag each, 0 and 7 raise none
    assign dec = (seq_sel_i != 3'h0 && seq_sel_i != 3'h7) ? N_SEQ_FLAGS'(1) << (seq_sel_i - 3'h1) : '0;
    assign flag_o = dec | extra_i;
    assign sub_done_o = done_ff;
    // a routine finishes done_lat_i + 1 cycles after its call opens, done is a one-cycle pulse
    always @(posedge ref_clk_i) begin
        wait_ff <= sub_call_i ? wait_ff + 4'h1 : 4'h0;
        done_ff <= sub_call_i && !done_ff && wait_ff >= done_lat_i;
    end
endmodule : fsd_far_side

/* File: dv/fault_status_display_manager_tb.sv */
// self-checking bench for the fault and status display manager
`timescale 1ns/1ps
module fault_status_display_manager_tb;
    import fsd_pkg::*;
    localparam int SAT = 8;
    logic ref_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    fsd_avs_req_s req = '0;
    logic [31:0] rdata;
    logic wreq, en = 1'b0, peot = 1'b0, neot = 1'b0, cw = 1'b0, ccw = 1'b0;
    logic oot = 1'b0, sat = 1'b0, ladder = 1'b0, seqe = 1'b0, phasing = 1'b0, done, call, amp, hflt;
    logic [7:0] fcond = '0, nfcond = '0, temp = '0, dg;
    logic [15:0] ferr = '0;
    logic [2:0] sel = '0, idx, first;
    logic [3:0] lat = 4'h1;
    logic [5:0] xfl = '0, flags;
    fsd_disp_s disp;
    int err_count = 0;
    int n_checks = 0;
    int cyc = 0;
    int fb;

    always #12.5 ref_clk_i = ~ref_clk_i;

    fsd_fault_status_mgr #(.SAT_CNT(SAT), .BLINK_CNT(4)) u_fsd_fault_status_mgr (
        .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .avs_req_i(req), .avs_readdata_o(rdata),
        .avs_waitrequest_o(wreq), .enable_pin_i(en), .pos_eot_pin_i(peot), .neg_eot_pin_i(neot),
        .cw_limit_pin_i(cw), .ccw_limit_pin_i(ccw), .fatal_cond_i(fcond), .cur_reg_oot_i(oot),
        .cur_fb_sat_i(sat), .heatsink_temp_i(temp), .ladder_err_i(ladder), .seq_prog_err_i(seqe),
        .nonfatal_cond_i(nfcond), .follow_err_i(ferr), .phasing_i(phasing),
        .ladder_to_sequencer_flag_i(flags), .sub_done_i(done), .sub_call_o(call), .sub_index_o(idx),
        .amp_enable_o(amp), .host_fault_o(hflt), .disp_o(disp));
    fsd_far_side u_fsd_far_side (.ref_clk_i(ref_clk_i), .seq_sel_i(sel), .extra_i(xfl),
        .done_lat_i(lat), .sub_call_i(call), .flag_o(flags), .sub_done_o(done));

    task automatic give_verdict();
        if (err_count == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : give_verdict

    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, e, g);
        end
    endtask : chk

    task automatic chk1(input string what, input logic e, input logic g);
        chk(what, 32'(e), 32'(g));
    endtask : chk1

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask : tick

    // one access: hold until waitrequest is sampled low, take data at that edge
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge ref_clk_i);
        req <= '{!w, w, a, d, 4'hf};
        @(posedge ref_clk_i);
        while (wreq !== 1'b0 && cyc < 20000) @(posedge ref_clk_i);
        q = rdata;
        req <= '0;
    endtask : bus

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr

    task automatic rd(input logic [4:0] a, input logic [31:0] e, input logic [31:0] m, input string what);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(what, e, q & m);
    endtask : rd

    task automatic see(input fsd_char_t a, input fsd_char_t b, input fsd_char_t c, input logic fl,
                       input string what);
        chk(what, 32'({fl, a, b, c}), 32'({disp.flash, disp.c0, disp.c1, disp.c2}));
    endtask : see

    task automatic blink();
        int t = 0;
        repeat (8) begin
            @(posedge ref_clk_i);
            t += (disp.lit === 1'b0) ? 1 : 0;
        end
        chk1("blank phase", 1'b1, t > 0 && t < 8);
    endtask : blink

    task automatic wait_call(input logic lvl);
        int t = 0;
        while (call !== lvl && t < 100) begin
            @(posedge ref_clk_i);
            t++;
        end
        chk1("call handshake", 1'b1, t < 100);
    endtask : wait_call

    task automatic power_up();
        rst_n_i <= 1'b0;
        {en, peot, neot, cw, ccw, oot, sat, ladder, seqe, phasing} <= '0;
        {fcond, nfcond, ferr, sel, xfl} <= '0;
        temp <= TEMP_LIMIT_C;
        tick(4);
        rst_n_i <= 1'b1;
        tick(3);
    endtask : power_up

    task automatic enable_cycle();
        en <= 1'b0;
        tick(5);
        en <= 1'b1;
        tick(6);
    endtask : enable_cycle

    always @(posedge ref_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            give_verdict();
        end
    end

    initial begin
        power_up();
        see(CH_F, CH_9, CH_9, 1'b1, "unconfigured");
        enable_cycle();
        chk1("amp unconfigured", 1'b0, amp);
        rd(REG_CTRL, 32'h0, 32'hffffffff, "ctrl reset");
        rd(REG_FE_LIMIT, 32'hffff, 32'hffffffff, "fe limit reset");
        rd(5'h14, 32'h0, 32'hffffffff, "unmapped");
        en <= 1'b0;
        wr(REG_CTRL, 32'h3);
        tick(4);
        see(CH_D, CH_BLANK, CH_BLANK, 1'b0, "disabled");
        enable_cycle();
        chk1("amp enabled", 1'b1, amp);
        see(CH_E, CH_BLANK, CH_BLANK, 1'b0, "enabled");
        rd(REG_STATUS, 32'h1, 32'hf, "status on");
        wr(REG_CTRL, 32'h2);
        tick(4);
        chk1("amp host off", 1'b0, amp);
        see(CH_D, CH_BLANK, CH_BLANK, 1'b0, "host off");
        wr(REG_CTRL, 32'h3);
        enable_cycle();
        cw <= 1'b1;
        tick(6);
        see(CH_L, CH_0, CH_1, 1'b1, "cw limit");
        blink();
        phasing <= 1'b1;
        tick(4);
        see(CH_P, CH_BLANK, CH_BLANK, 1'b0, "phasing");
        phasing <= 1'b0;
        cw <= 1'b0;
        ccw <= 1'b1;
        tick(6);
        see(CH_L, CH_0, CH_2, 1'b1, "ccw limit");
        en <= 1'b0;
        tick(6);
        see(CH_D, CH_BLANK, CH_BLANK, 1'b0, "limit disabled");
        for (int k = 0; k < 13; k++) begin
            power_up();
            chk1("fault after power cycle", 1'b0, hflt);
            wr(REG_CTRL, 32'h3);
            enable_cycle();
            sat <= 1'b1;
            tick(SAT - 2);
            sat <= 1'b0;
            tick(4);
            chk1("armed", 1'b1, amp);
            case (k)
                8: ladder <= 1'b1;
                9: seqe <= 1'b1;
                10: sat <= 1'b1;
                11: temp <= TEMP_LIMIT_C + 8'h1;
                12: oot <= 1'b1;
                default: fcond[k] <= 1'b1;
            endcase
            nfcond[0] <= 1'b1;
            peot <= 1'b1;
            tick(SAT + 4);
            dg = (k < 8) ? 8'(k) : (k == 8) ? 8'h98 : (k == 9) ? 8'h97 : (k == 11) ? 8'h05 : 8'h04;
            fb = (k < 10) ? k : (k == 11) ? 5 : 4;
            see(CH_F, dg[7:4], dg[3:0], 1'b1, "fatal code");
            blink();
            chk1("amp on fatal", 1'b0, amp);
            chk1("host fault", 1'b1, hflt);
            rd(REG_FAULTS, (32'h1 << fb) | 32'h01010000, 32'h03ff03ff, "sticky");
            {fcond, nfcond, ladder, seqe, sat, oot, peot} <= '0;
            temp <= TEMP_LIMIT_C;
            enable_cycle();
            chk1("fatal held", 1'b0, amp);
        end
        power_up();
        wr(REG_CTRL, 32'h3);
        enable_cycle();
        for (int i = 0; i < 10; i++) begin
            if (i == 4) begin
                wr(REG_CTRL, 32'h7);
                wr(REG_FE_LIMIT, 32'h100);
                ferr <= 16'h00ff;
                tick(4);
                chk1("below limit", 1'b1, amp);
                ferr <= 16'h0100;
            end else if (i == 8)
                peot <= 1'b1;
            else if (i == 9)
                neot <= 1'b1;
            else
                nfcond[i] <= 1'b1;
            tick(6);
            dg = (i < 8) ? 8'h51 + 8'(i) : 8'hb1 + 8'(i - 8);
            see(CH_F, dg[7:4], dg[3:0], 1'b1, "nonfatal code");
            chk1("amp on fault", 1'b0, amp);
            enable_cycle();
            chk1("held with cause", 1'b0, amp);
            {nfcond, ferr, peot, neot} <= '0;
            tick(6);
            chk1("held until enable", 1'b0, amp);
            enable_cycle();
            chk1("cleared", 1'b1, amp);
        end
        wr(REG_CTRL, 32'h3);
        ferr <= 16'hffff;
        tick(6);
        chk1("no position mode", 1'b1, amp);
        ferr <= '0;
        for (int s = 1; s <= 6; s++) begin
            sel <= 3'(s);
            lat <= 4'(s);
            wait_call(1'b1);
            chk("index", 32'(s), 32'(idx));
            sel <= 3'h0;
            wait_call(1'b0);
        end
        xfl <= 6'h24;
        wait_call(1'b1);
        first = idx;
        wait_call(1'b0);
        wait_call(1'b1);
        chk("next index", 32'(3'h3 ^ 3'h6 ^ first), 32'(idx));
        xfl <= '0;
        wait_call(1'b0);
        give_verdict();
    end
endmodule : fault_status_display_manager_tb
